// ---- sgp_driver.v ----
`timescale 1ns/10ps
// Notes on behaviour
// - each shift clock rise shifts serial_in into the register toward msb
// - cascade_out is an extra stage after msb, loaded on shift clock fall
// - latch strobe rise copies the whole shift register into the data latch
// - after latch rise all outputs stay off until the next pwm period
// - latch strobe rise does not reset or stop the grayscale counter
// - blank high forces every sink output off
// - blank high reinitialises pwm timing and holds counter at zero
// - blank low: outputs follow pwm counter versus latched grayscale values
// - turn-on staggered in four channel groups, later groups delayed
// - internal oscillator nominally 4 mhz, derived from the system clock
`include "sgp_regs.vh"
module sgp_driver #(
    parameter NUM_CH = `SGP_NUM_CH,
    parameter GS_BITS = `SGP_GS_BITS,
    parameter OSC_DIV = (1000000 / `SGP_CLK_NS) / `SGP_OSC_KHZ
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire serial_in,
    input wire shift_clk_in,
    input wire latch_strobe_in,
    input wire blank_in,
    output reg cascade_out,
    output reg [NUM_CH-1:0] sink_outputs_out,
    output wire shift_ready_out
);
    localparam SR_BITS = NUM_CH * GS_BITS;
    localparam G1 = (`SGP_GRP1_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS;
    localparam G2 = (`SGP_GRP2_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS;
    localparam G3 = (`SGP_GRP3_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS;
    localparam DIV = (OSC_DIV < 1) ? 1 : OSC_DIV;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // two flops per pin before any logic reads it
    reg [1:0] sck_s_q;
    reg [1:0] sin_s_q;
    reg [1:0] lat_s_q;
    reg [1:0] blk_s_q;
    reg sck_d1_q;
    reg lat_d1_q;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sck_s_q <= 2'h0;
            sin_s_q <= 2'h0;
            lat_s_q <= 2'h0;
            blk_s_q <= 2'h3;
            sck_d1_q <= 1'b0;
            lat_d1_q <= 1'b0;
        end else begin
            sck_s_q <= {sck_s_q[0], shift_clk_in};
            sin_s_q <= {sin_s_q[0], serial_in};
            lat_s_q <= {lat_s_q[0], latch_strobe_in};
            blk_s_q <= {blk_s_q[0], blank_in};
            sck_d1_q <= sck_s_q[1];
            lat_d1_q <= lat_s_q[1];
        end
    end

    // ************************************************************
    // edge detection
    // ************************************************************
    wire sck_rise = sck_s_q[1] && !sck_d1_q;
    wire sck_fall = !sck_s_q[1] && sck_d1_q;
    wire lat_rise = lat_s_q[1] && !lat_d1_q;
    wire blank = blk_s_q[1];

    // ************************************************************
    // bit fifo between pin sampler and shift register
    // ************************************************************
    wire fifo_valid;
    wire fifo_bit;
    wire fifo_ready;
    wire fifo_pop;
    sgp_fifo #(
        .WIDTH(1),
        .DEPTH(`SGP_FIFO_DEPTH),
        .AW(3)
    ) i_sgp_fifo (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(sck_rise),
        .in_ready_out(fifo_ready),
        .in_data_in(sin_s_q[1]),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_bit)
    );
    assign shift_ready_out = fifo_ready;
    // bits move on as soon as they are sampled, never held back
    assign fifo_pop = fifo_valid;

    // ************************************************************
    // shift register
    // ************************************************************
    reg [SR_BITS-1:0] shreg_q;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            shreg_q <= {SR_BITS{1'b0}};
        end else if (fifo_pop) begin
            shreg_q <= {shreg_q[SR_BITS-2:0], fifo_bit};
        end
    end

    // ************************************************************
    // cascade stage
    // ************************************************************
    // a fall seen with bits still queued waits for them to land
    reg casc_pend_q;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            casc_pend_q <= 1'b0;
            cascade_out <= 1'b0;
        end else begin
            if (sck_fall && fifo_valid) begin
                casc_pend_q <= 1'b1;
            end else if (!fifo_valid) begin
                casc_pend_q <= 1'b0;
            end
            if ((sck_fall || casc_pend_q) && !fifo_valid) begin
                cascade_out <= shreg_q[SR_BITS-1];
            end
        end
    end

    // ************************************************************
    // data latch
    // ************************************************************
    // latch waits until every sampled bit has reached the register
    reg [SR_BITS-1:0] latch_q;
    reg lat_pend_q;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            latch_q <= {SR_BITS{1'b0}};
            lat_pend_q <= 1'b0;
        end else if (lat_rise) begin
            lat_pend_q <= 1'b1;
        end else if (lat_pend_q && !fifo_valid) begin
            lat_pend_q <= 1'b0;
            latch_q <= shreg_q;
        end
    end

    // ************************************************************
    // post-latch blanking window
    // ************************************************************
    reg blank_until_period_q;
    wire period_start;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            blank_until_period_q <= 1'b0;
        end else if (lat_rise) begin
            blank_until_period_q <= 1'b1;
        end else if (period_start || blank) begin
            blank_until_period_q <= 1'b0;
        end
    end

    // ************************************************************
    // internal oscillator and grayscale counter
    // ************************************************************
    reg [15:0] div_q;
    reg [GS_BITS-1:0] gs_cnt_q;
    // tick at the nominal oscillator rate
    wire osc_tick = (div_q == DIV[15:0] - 16'h0001);
    assign period_start = osc_tick && (gs_cnt_q == {GS_BITS{1'b1}});
    // free-running counter; a latch never clears it
    always @(posedge ref_clk_in) begin
        if (sys_rst_in || blank) begin
            div_q <= 16'h0000;
            gs_cnt_q <= {GS_BITS{1'b0}};
        end else begin
            div_q <= osc_tick ? 16'h0000 : div_q + 16'h0001;
            if (osc_tick) begin
                gs_cnt_q <= gs_cnt_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // per channel compare and output
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            wire [GS_BITS-1:0] gs_val = latch_q[ch*GS_BITS +: GS_BITS];
            // compare against the latched value, off while blanked
            wire want = !blank && !blank_until_period_q && (gs_cnt_q < gs_val);
            reg [G3:0] hist_q;
            wire grp_on;
            always @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    hist_q <= {(G3+1){1'b0}};
                end else begin
                    hist_q <= {hist_q[G3-1:0], want};
                end
            end
            // later groups turn on after a delay, all turn off at once
            if (ch % 4 == 0) begin : g0
                assign grp_on = want;
            end else if (ch % 4 == 1) begin : g1
                assign grp_on = want && hist_q[G1-1];
            end else if (ch % 4 == 2) begin : g2
                assign grp_on = want && hist_q[G2-1];
            end else begin : g3
                assign grp_on = want && hist_q[G3-1];
            end
            always @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    sink_outputs_out[ch] <= 1'b0;
                end else begin
                    sink_outputs_out[ch] <= grp_on && !blank;
                end
            end
        end
    endgenerate
endmodule // sgp_driver

// ---- sgp_regs.vh ----
`ifndef SGP_REGS_VH
`define SGP_REGS_VH
// channel layout
`define SGP_NUM_CH 24
`define SGP_GS_BITS 12
`define SGP_SR_BITS 288
// pwm period in pwm ticks
`define SGP_PWM_PERIOD 4096
// system clock period in ns
`define SGP_CLK_NS 25
// internal oscillator nominal rate in khz
`define SGP_OSC_KHZ 4000
// host guard time after latch rise, ns
`define SGP_LAT_GUARD_NS 100
// group turn-on delays in ns
`define SGP_GRP1_NS 24
`define SGP_GRP2_NS 48
`define SGP_GRP3_NS 72
// fifo depth
`define SGP_FIFO_DEPTH 8
`endif

// ---- sgp_fifo.v ----
`timescale 1ns/10ps
module sgp_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output reg [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    wire [AW-1:0] rd_nx;

    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign rd_nx = (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;

    always @(posedge ref_clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
        if (sys_rst_in) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_nx;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // combinational head word, not registered
    always @* begin
        out_data_out = mem_q[rd_q];
    end
endmodule // sgp_fifo

// ---- sgp_driver_checker.sv ----
`timescale 1ns/10ps
// ****************
// port checks
// ****************
module sgp_driver_checker #(parameter NUM_CH = 24) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire shift_clk_in,
    input wire latch_strobe_in,
    input wire blank_in,
    input wire cascade_out,
    input wire [NUM_CH-1:0] sink_outputs_out,
    input wire shift_ready_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_rst; $past(sys_rst_in) |-> sink_outputs_out == 0 && !cascade_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
    property p_blank; blank_in [*5] |-> sink_outputs_out == 0; endproperty
    a_blank: assert property (p_blank) else $error("output on while blanked");
    property p_unblank; $fell(blank_in) |-> sink_outputs_out == 0 [*2]; endproperty
    a_unblank: assert property (p_unblank) else $error("output on at unblank");
    property p_latch; $rose(latch_strobe_in) |-> ##5 sink_outputs_out == 0 [*8]; endproperty
    a_latch: assert property (p_latch) else $error("output on after latch");
    property p_stagger; $rose(sink_outputs_out[0]) |-> sink_outputs_out[3:1] == 3'h0; endproperty
    a_stagger: assert property (p_stagger) else $error("group not delayed");
    property p_casc; $changed(cascade_out) |-> !$past(shift_clk_in, 2); endproperty
    a_casc: assert property (p_casc) else $error("cascade moved off fall");
    property p_casc_idle; !shift_clk_in [*8] |-> $stable(cascade_out); endproperty
    a_casc_idle: assert property (p_casc_idle) else $error("cascade moved idle");
    property p_ready; shift_ready_out; endproperty
    a_ready: assert property (p_ready) else $error("shift path refused");
endmodule // sgp_driver_checker
bind sgp_driver sgp_driver_checker #(.NUM_CH(NUM_CH)) i_sgp_driver_checker (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .shift_clk_in(shift_clk_in),
    .latch_strobe_in(latch_strobe_in), .blank_in(blank_in), .cascade_out(cascade_out),
    .sink_outputs_out(sink_outputs_out), .shift_ready_out(shift_ready_out));

// ---- sgp_host_model.sv ----
`timescale 1ns/10ps
// ****************
// host side
// ****************
module sgp_host_model (
    input wire cascade_in,
    output reg serial_out = 1'b0,
    output reg shift_clk_out = 1'b0,
    output reg latch_out = 1'b0
);
    task load(input [287:0] frame, output [287:0] seen);
        integer k;
        begin
            for (k = 287; k >= 0; k = k - 1) begin
                serial_out = frame[k];
                #50 shift_clk_out = 1'b1;
                #50 seen[k] = cascade_in;
                #50 shift_clk_out = 1'b0;
                #50;
            end
            serial_out = ~serial_out;
            latch_out = 1'b1;
            #100 latch_out = 1'b0;
            #100;
        end
    endtask
endmodule // sgp_host_model

// ---- sgp_driver_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
    fail_count = fail_count + 1; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
// ****************
// bench
// ****************
module sgp_driver_tb;
    reg ref_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg blank_in = 1'b1;
    reg last0 = 1'b0;
    wire serial_in, shift_clk_in, latch_strobe_in, cascade_out, shift_ready_out;
    wire [23:0] sink_outputs_out;
    integer fail_count = 0, comparisons = 0, cyc = 0, rise_t = 0, n, t0, bad, d;
    reg [287:0] frame, seen;
    reg [11:0] cnt [0:23];
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        last0 <= sink_outputs_out[0];
        if (sink_outputs_out[0] && !last0) rise_t <= cyc;
    end
    sgp_driver #(.OSC_DIV(1)) i_sgp_driver (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .serial_in(serial_in), .shift_clk_in(shift_clk_in), .latch_strobe_in(latch_strobe_in),
        .blank_in(blank_in), .cascade_out(cascade_out), .sink_outputs_out(sink_outputs_out),
        .shift_ready_out(shift_ready_out));
    sgp_host_model i_sgp_host_model (.cascade_in(cascade_out), .serial_out(serial_in),
        .shift_clk_out(shift_clk_in), .latch_out(latch_strobe_in));
    task wait_rise;
        integer w, r;
        begin
            r = rise_t;
            bad = 0;
            for (w = 0; w < 5000 && rise_t == r; w = w + 1) begin
                @(posedge ref_clk_in) #1;
                bad = bad + sink_outputs_out[23];
            end
            if (rise_t == r) fail_count = fail_count + 1;
        end
    endtask
    task t_cascade;
        begin
            i_sgp_host_model.load({9{32'h5a3c96e1}}, seen);
            i_sgp_host_model.load(~{9{32'h5a3c96e1}}, seen);
            `CHK(seen, {9{32'h5a3c96e1}})
        end
    endtask
    task t_pwm;
        begin
            for (n = 0; n < 24; n = n + 1)
                frame[12*n +: 12] = (n == 4) ? 12'h000 : (n == 23) ? 12'hfff : 12'h010 * (n + 1);
            i_sgp_host_model.load(frame, seen);
            @(posedge ref_clk_in) #1 blank_in = 1'b0;
            repeat (10) @(posedge ref_clk_in);
            for (n = 0; n < 24; n = n + 1) cnt[n] = 12'h000;
            repeat (4096) begin
                @(posedge ref_clk_in) #1;
                for (n = 0; n < 24; n = n + 1) cnt[n] = cnt[n] + sink_outputs_out[n];
            end
            for (n = 0; n < 24; n = n + 1) begin
                // group n%4 turns on n%4 cycles late; off gap and value cap the loss
                d = n % 4;
                if (4096 - frame[12*n +: 12] < d) d = 4096 - frame[12*n +: 12];
                if (frame[12*n +: 12] < d) d = frame[12*n +: 12];
                `CHK(cnt[n], frame[12*n +: 12] - d)
            end
        end
    endtask
    task t_latch;
        begin
            wait_rise;
            t0 = rise_t;
            repeat (100) @(posedge ref_clk_in);
            i_sgp_host_model.load(frame, seen);
            wait_rise;
            `CHK(bad, 0)
            `CHK((rise_t - t0) % 4096, 0)
        end
    endtask
    task t_blank;
        begin
            wait_rise;
            repeat (1000) @(posedge ref_clk_in);
            #1 blank_in = 1'b1;
            repeat (20) @(posedge ref_clk_in);
            #1 `CHK(sink_outputs_out, 24'h000000)
            blank_in = 1'b0;
            t0 = cyc;
            wait_rise;
            `CHK(rise_t - t0 < 12, 1'b1)
        end
    endtask
    task conclude;
        begin
            if (fail_count == 0 && comparisons > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        t_cascade;
        t_pwm;
        t_latch;
        t_blank;
        conclude;
    end
    initial begin
        #(60000 * 25);
        fail_count = fail_count + 1;
        conclude;
    end
endmodule // sgp_driver_tb
